/* File: design/twp_master.sv */
// Purpose: Master part of a two-wire port: stop, byte transmit with ack sample, byte receive.
// Assumes: APB slave registers; SCL/SDA inputs synchronous to i_ref_clk.
// Notes: Open-drain pins: output enable low means the pin is pulled low.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - After a byte's ninth falling edge SCL stays low before any stop.
// - Stop enable drives SDA low; once sampled low, rate generator reloads and counts.
// - In stop, on overflow release SCL; one period later release SDA.
// - Set stop-detected flag when SDA sampled high while SCL high.
// - One period after stop seen, clear stop enable and set interrupt flag.
// - Buffer write during stop sets write collision, buffer unchanged.
// - Released SCL pauses generator until SCL high, then reload and count.
// - Buffer write in master mode sets buffer full and starts transmission.
// - Bits shift out on SCL falling edge: seven address bits then direction.
// - On ninth falling edge sample SDA into ack status.
// - After ack: set interrupt, clear buffer full, halt with SCL low, SDA free.
// - Transmit clears buffer full after all eight bits shifted out.
// - Buffer write during transmit sets write collision, buffer unchanged.
// - Ack status reads zero on acknowledge, one on no acknowledge.
// - Receive enable starts generator; bits shift in on SCL rising edge.
// - After eighth falling edge: clear receive enable, load buffer, flag, idle.
// - Receive buffer full clears when software reads the buffer.
// - Overflow set when a byte completes while buffer full still set.
// - Buffer write during receive sets write collision, buffer unchanged.
// - Software may set ack sequence enable after a received byte.
// - Reload from low seven rate bits; SCL rate follows clock over that value.
// - Interrupt flag set by sequence events; output gated by interrupt enable.
// - Master mode needs master select and port enable both set.
module twp_master (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  output logic o_irq
);
  typedef enum {TWP_IDLE, TWP_STOP_LOW, TWP_STOP_SCL, TWP_STOP_SDA, TWP_STOP_END, TWP_TX_LOW,
    TWP_TX_HIGH, TWP_RX_LOW, TWP_RX_HIGH, TWP_ACK_LOW, TWP_ACK_HIGH, TWP_ACK_END} twp_state_e;

  twp_state_e state_ff, nxt_state;
  logic [2:0] ctrl_ff;
  logic stop_en_ff, recv_en_ff, ack_en_ff, ack_data_ff;
  logic [6:0] rate_ff;
  logic [7:0] buf_ff, shift_ff;
  logic buf_full_ff, write_collision_ff, ovf_ff, ack_status_flag_ff, stop_seen_ff, irq_flag_ff;
  logic [3:0] bit_cnt_ff;
  logic scl_low_ff, sda_low_ff;
  logic scl_prev_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;

  // APB decode: zero-wait answer in the access cycle
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire hit_ctrl = paddr == twp_pkg::ADDR_CTRL;
  wire hit_c2 = paddr == twp_pkg::ADDR_CTRL2;
  wire hit_stat = paddr == twp_pkg::ADDR_STAT;
  wire hit_data = paddr == twp_pkg::ADDR_DATA;
  wire hit_rate = paddr == twp_pkg::ADDR_RATE;
  wire mapped = hit_ctrl | hit_c2 | hit_stat | hit_data | hit_rate;

  wire master_on = ctrl_ff[twp_pkg::CTRL_PORT_EN] && ctrl_ff[twp_pkg::CTRL_MASTER_SEL];
  wire idle = state_ff == TWP_IDLE;
  wire busy = !idle;
  wire data_wr = wr && hit_data;
  wire c2_wr = wr && hit_c2;
  wire start_tx = data_wr && idle && master_on;
  wire start_stop = c2_wr && idle && master_on && pwdata[twp_pkg::C2_STOP_EN];
  wire start_rx = c2_wr && idle && master_on && !pwdata[twp_pkg::C2_STOP_EN]
    && pwdata[twp_pkg::C2_RECV_EN];
  wire start_ack = c2_wr && idle && master_on && !pwdata[twp_pkg::C2_STOP_EN]
    && !pwdata[twp_pkg::C2_RECV_EN] && pwdata[twp_pkg::C2_ACK_EN];
  wire collide = data_wr && busy;

  wire scl_rise = i_scl && !scl_prev_ff;
  wire ovf;
  logic reload, run;
  logic set_irq, set_stop_seen, take_ack, rx_done, tx_byte_done;

  twp_rate_gen #(.WIDTH(7)) twp_rate_gen_inst (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_reload(reload),
    .i_run(run),
    .i_value(rate_ff),
    .o_ovf(ovf)
  );

  always_comb begin
    nxt_state = state_ff;
    reload = 1'b0;
    run = 1'b1;
    set_irq = 1'b0;
    set_stop_seen = 1'b0;
    take_ack = 1'b0;
    rx_done = 1'b0;
    tx_byte_done = 1'b0;
    case (state_ff)
      TWP_IDLE: begin
        if (start_stop) begin
          nxt_state = TWP_STOP_LOW;
        end else if (start_tx || start_rx || start_ack) begin
          reload = 1'b1;
          nxt_state = start_tx ? TWP_TX_LOW : (start_rx ? TWP_RX_LOW : TWP_ACK_LOW);
        end
      end
      TWP_STOP_LOW: begin
        if (!i_sda) begin
          reload = 1'b1;
          nxt_state = TWP_STOP_SCL;
        end
      end
      TWP_STOP_SCL: begin
        if (ovf) begin
          nxt_state = TWP_STOP_SDA;
        end
      end
      TWP_STOP_SDA: begin
        run = i_scl;
        if (scl_rise) begin
          reload = 1'b1;
        end else if (ovf && i_scl) begin
          nxt_state = TWP_STOP_END;
        end
      end
      TWP_STOP_END: begin
        if (i_sda && i_scl && !stop_seen_ff) begin
          set_stop_seen = 1'b1;
          reload = 1'b1;
        end else if (ovf && stop_seen_ff) begin
          set_irq = 1'b1;
          nxt_state = TWP_IDLE;
        end
      end
      TWP_TX_LOW, TWP_RX_LOW, TWP_ACK_LOW: begin
        if (ovf) begin
          nxt_state = state_ff == TWP_TX_LOW ? TWP_TX_HIGH : (state_ff == TWP_RX_LOW ? TWP_RX_HIGH : TWP_ACK_HIGH);
        end
      end
      TWP_TX_HIGH, TWP_RX_HIGH, TWP_ACK_HIGH: begin
        run = i_scl;
        if (scl_rise) begin
          reload = 1'b1;
        end else if (ovf && i_scl) begin
          reload = 1'b1;
          if (state_ff == TWP_TX_HIGH) begin
            if (bit_cnt_ff == twp_pkg::BITS_TX - 4'h1) begin
              take_ack = 1'b1;
              set_irq = 1'b1;
              nxt_state = TWP_IDLE;
            end else begin
              tx_byte_done = bit_cnt_ff == twp_pkg::BITS_RX - 4'h1;
              nxt_state = TWP_TX_LOW;
            end
          end else if (state_ff == TWP_RX_HIGH) begin
            if (bit_cnt_ff == twp_pkg::BITS_RX - 4'h1) begin
              rx_done = 1'b1;
              set_irq = 1'b1;
              nxt_state = TWP_IDLE;
            end else begin
              nxt_state = TWP_RX_LOW;
            end
          end else begin
            nxt_state = TWP_ACK_END;
          end
        end
      end
      TWP_ACK_END: begin
        if (ovf) begin
          set_irq = 1'b1;
          nxt_state = TWP_IDLE;
        end
      end
      default: nxt_state = TWP_IDLE;
    endcase
    if (!master_on) begin
      nxt_state = TWP_IDLE;
    end
  end

  // Pin drive targets per state
  wire in_tx = state_ff == TWP_TX_LOW || state_ff == TWP_TX_HIGH;
  wire nxt_scl_low = nxt_state == TWP_IDLE ? ((scl_low_ff || take_ack || rx_done) && master_on) :
    (nxt_state == TWP_STOP_LOW || nxt_state == TWP_STOP_SCL || nxt_state == TWP_TX_LOW
    || nxt_state == TWP_RX_LOW || nxt_state == TWP_ACK_LOW || nxt_state == TWP_ACK_END);
  wire tx_bit = shift_ff[7];
  wire nxt_sda_low = (nxt_state == TWP_STOP_LOW || nxt_state == TWP_STOP_SCL
    || nxt_state == TWP_STOP_SDA) ? 1'b1 :
    (nxt_state == TWP_TX_LOW || nxt_state == TWP_TX_HIGH) ? (bit_cnt_ff < twp_pkg::BITS_RX ? !tx_bit : 1'b0) :
    (nxt_state == TWP_ACK_LOW || nxt_state == TWP_ACK_HIGH) ? !ack_data_ff : 1'b0;

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= TWP_IDLE;
      bit_cnt_ff <= '0;
      shift_ff <= '0;
      scl_low_ff <= 1'b0;
      sda_low_ff <= 1'b0;
      scl_prev_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      scl_low_ff <= nxt_scl_low;
      sda_low_ff <= nxt_sda_low;
      scl_prev_ff <= i_scl;
      if (state_ff == TWP_IDLE) begin
        bit_cnt_ff <= '0;
        if (start_tx) begin
          shift_ff <= pwdata[7:0];
        end
      end else if ((state_ff == TWP_TX_HIGH || state_ff == TWP_RX_HIGH) && nxt_state != state_ff) begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
        if (in_tx) begin
          shift_ff <= {shift_ff[6:0], 1'b0};
        end
      end
      if (state_ff == TWP_RX_HIGH && scl_rise) begin
        shift_ff <= {shift_ff[6:0], i_sda};
      end
    end
  end

  // Software registers and flags; hardware set wins over software clear
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_ff <= '0;
      stop_en_ff <= 1'b0;
      recv_en_ff <= 1'b0;
      ack_en_ff <= 1'b0;
      ack_data_ff <= 1'b0;
      rate_ff <= twp_pkg::RATE_RESET;
      buf_ff <= '0;
      buf_full_ff <= 1'b0;
      write_collision_ff <= 1'b0;
      ovf_ff <= 1'b0;
      ack_status_flag_ff <= 1'b0;
      stop_seen_ff <= 1'b0;
      irq_flag_ff <= 1'b0;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_ff <= pwdata[2:0];
      end
      if (wr && hit_rate) begin
        rate_ff <= pwdata[6:0];
      end
      if (c2_wr) begin
        ack_data_ff <= pwdata[twp_pkg::C2_ACK_DATA];
      end
      if (start_stop) begin
        stop_en_ff <= 1'b1;
        stop_seen_ff <= 1'b0;
      end else if (state_ff == TWP_STOP_END && nxt_state == TWP_IDLE) begin
        stop_en_ff <= 1'b0;
      end
      if (start_rx) begin
        recv_en_ff <= 1'b1;
      end else if (rx_done || !master_on) begin
        recv_en_ff <= 1'b0;
      end
      if (start_ack) begin
        ack_en_ff <= 1'b1;
      end else if (state_ff == TWP_ACK_END || !master_on) begin
        ack_en_ff <= 1'b0;
      end
      if (!master_on) begin
        stop_en_ff <= 1'b0;
      end
      if (start_tx) begin
        buf_ff <= pwdata[7:0];
      end else if (rx_done) begin
        buf_ff <= shift_ff;
      end
      if (start_tx || rx_done) begin
        buf_full_ff <= 1'b1;
      end else if (tx_byte_done || take_ack || (rd && hit_data)) begin
        buf_full_ff <= 1'b0;
      end
      if (rx_done && buf_full_ff) begin
        ovf_ff <= 1'b1;
      end else if (wr && hit_stat && !pwdata[twp_pkg::ST_OVF]) begin
        ovf_ff <= 1'b0;
      end
      if (collide) begin
        write_collision_ff <= 1'b1;
      end else if (wr && hit_stat && !pwdata[twp_pkg::ST_WRITE_COLLISION]) begin
        write_collision_ff <= 1'b0;
      end
      if (take_ack) begin
        ack_status_flag_ff <= i_sda;
      end
      if (set_stop_seen) begin
        stop_seen_ff <= 1'b1;
      end else if (wr && hit_stat && !pwdata[twp_pkg::ST_STOP_SEEN]) begin
        stop_seen_ff <= 1'b0;
      end
      if (set_irq) begin
        irq_flag_ff <= 1'b1;
      end else if (wr && hit_stat && !pwdata[twp_pkg::ST_IRQ]) begin
        irq_flag_ff <= 1'b0;
      end
    end
  end

  wire [31:0] stat_word = {25'h0, busy, irq_flag_ff, stop_seen_ff, ack_status_flag_ff, ovf_ff, write_collision_ff, buf_full_ff};
  wire [31:0] c2_word = {26'h0, ack_data_ff, ack_en_ff, recv_en_ff, 1'b0, stop_en_ff, 1'b0};
  wire [31:0] rd_word = hit_ctrl ? {29'h0, ctrl_ff} : hit_c2 ? c2_word : hit_stat ? stat_word :
    hit_data ? {24'h0, buf_ff} : hit_rate ? {25'h0, rate_ff} : 32'h0;

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      prdata_ff <= '0;
      pslverr_ff <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      prdata_ff <= (psel && !penable && !pwrite) ? rd_word : prdata_ff;
      pslverr_ff <= psel && !penable && !mapped;
      o_irq <= irq_flag_ff && ctrl_ff[twp_pkg::CTRL_IRQ_EN];
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = pslverr_ff;
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;
  assign o_scl_oe = !scl_low_ff;
  assign o_sda_oe = !sda_low_ff;
endmodule : twp_master
`default_nettype wire

/* File: design/twp_pkg.sv */
// Purpose: Shared constants for the two-wire port master (stop, transmit, receive).
// Assumes: APB slave, 32-bit data, one word per register.
// Notes: Offsets are byte addresses.
package twp_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0c;
  localparam logic [7:0] ADDR_RATE = 8'h10;
  // Control fields
  localparam int CTRL_PORT_EN = 0;
  localparam int CTRL_MASTER_SEL = 1;
  localparam int CTRL_IRQ_EN = 2;
  // master_control_two fields
  localparam int C2_STOP_EN = 1;
  localparam int C2_RECV_EN = 3;
  localparam int C2_ACK_EN = 4;
  localparam int C2_ACK_DATA = 5;
  // Status fields
  localparam int ST_BUF_FULL = 0;
  localparam int ST_WRITE_COLLISION = 1;
  localparam int ST_OVF = 2;
  localparam int ST_ACK_STATUS_FLAG = 3;
  localparam int ST_STOP_SEEN = 4;
  localparam int ST_IRQ = 5;
  localparam int ST_BUSY = 6;
  localparam logic [6:0] RATE_RESET = 7'h05;
  localparam logic [3:0] BITS_TX = 4'h9;
  localparam logic [3:0] BITS_RX = 4'h8;
endpackage : twp_pkg

/* File: design/twp_rate_gen.sv */
// Purpose: Rate generator down counter that times each SCL phase.
// Assumes: Reload value is the low seven bits of the rate register.
// Notes: Counts down to zero then stops; pulse o_ovf once on reaching zero.
`timescale 1ns/1ps
`default_nettype none
module twp_rate_gen #(
  parameter int WIDTH = 7
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_reload,
  input wire logic i_run,
  input wire logic [WIDTH-1:0] i_value,
  output logic o_ovf
);
  logic [WIDTH-1:0] cnt_ff;
  logic active_ff;
  wire done = active_ff && i_run && (cnt_ff <= {{(WIDTH-1){1'b0}}, 1'b1});

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_ff <= '0;
      active_ff <= 1'b0;
      o_ovf <= 1'b0;
    end else begin
      o_ovf <= done;
      if (i_reload) begin
        cnt_ff <= i_value;
        active_ff <= 1'b1;
      end else if (done) begin
        cnt_ff <= '0;
        active_ff <= 1'b0;
      end else if (active_ff && i_run) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule : twp_rate_gen
`default_nettype wire

/* File: verif/twp_master_properties.sv */
// Purpose: Port checks of the two-wire master.
// Assumes: i_scl and i_sda carry the pulled-up wire levels.
// Notes: MIN_HIGH is the least SCL high time at the bench rate.
`timescale 1ns/1ps
`default_nettype none
module twp_master_properties #(
  parameter int MIN_HIGH = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_scl_oe,
  input wire logic o_sda_oe,
  input wire logic o_irq
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  logic [7:0] hi_cnt;
  wire logic bad_addr = psel && penable && !(paddr inside {twp_pkg::ADDR_CTRL, twp_pkg::ADDR_CTRL2,
    twp_pkg::ADDR_STAT, twp_pkg::ADDR_DATA, twp_pkg::ADDR_RATE});
  // Cycles that SCL has really been high
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      hi_cnt <= 8'h00;
    end else begin
      hi_cnt <= i_scl ? hi_cnt + {7'h00, hi_cnt != 8'hff} : 8'h00;
    end
  end
  sequence sda_up_hi;
    $rose(o_sda_oe) && i_scl;
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_map: assert property (bad_addr |-> pslverr)
    else $error("no error on unmapped address");
  a_err_only: assert property (pslverr |-> bad_addr)
    else $error("error on mapped address");
  a_sda_fall_low: assert property ($fell(o_sda_oe) |-> !o_scl_oe)
    else $error("SDA pulled while SCL free");
  a_scl_high_min: assert property ($fell(o_scl_oe) |-> hi_cnt >= MIN_HIGH)
    else $error("SCL high too short");
  a_stop_order: assert property (sda_up_hi |-> o_scl_oe && $past(o_scl_oe, 2))
    else $error("SDA freed too early");
  a_stop_irq: assert property (sda_up_hi ##0 !o_irq |-> !o_irq [*2] ##[1:400] o_irq)
    else $error("stop interrupt timing");
  a_irq_cause: assert property ($rose(o_irq) |-> !o_scl_oe || (o_sda_oe && i_sda && i_scl))
    else $error("interrupt without cause");
endmodule : twp_master_properties
bind twp_master twp_master_properties twp_master_properties_inst (.i_ref_clk, .i_reset, .psel, .penable,
  .paddr, .pready, .pslverr, .i_scl, .i_sda, .o_scl_oe, .o_sda_oe, .o_irq);
`default_nettype wire

/* File: verif/twp_slave_model.sv */
// Purpose: Two-wire slave: acks bytes, sends bytes, stretches SCL.
// Assumes: Pulled-up lines; oe low pulls the line low.
// Notes: i_clr restarts a byte; data moves on SCL falls.
`timescale 1ns/1ps
`default_nettype none
module twp_slave_model (
  input wire logic i_ref_clk,
  input wire logic i_clr,
  input wire logic i_scl,
  input wire logic i_mst_scl_oe,
  input wire logic i_ack,
  input wire logic i_send,
  input wire logic [7:0] i_byte,
  input wire logic [7:0] i_stretch,
  output logic o_scl_oe,
  output logic o_sda_oe
);
  logic scl_q = 1'b1;
  logic mst_q = 1'b1;
  logic ack_on = 1'b0;
  logic bit_q = 1'b1;
  logic [3:0] rc = 4'h0;
  logic [7:0] hold = 8'h00;
  always @(posedge i_ref_clk) begin
    scl_q <= i_scl;
    mst_q <= i_mst_scl_oe;
    hold <= (i_mst_scl_oe && !mst_q) ? i_stretch : hold - {7'h00, hold != 8'h00};
    if (i_clr) begin
      rc <= 4'h0;
      ack_on <= 1'b0;
      bit_q <= i_byte[7];
    end else if (!scl_q && i_scl) begin
      rc <= rc + 4'h1;
    end else if (scl_q && !i_scl) begin
      ack_on <= i_ack && rc == 4'h8;
      bit_q <= rc < 4'h8 ? i_byte[3'h7 - rc[2:0]] : 1'b1;
      rc <= rc == 4'h9 ? 4'h0 : rc;
    end
  end
  // Keep SCL low for i_stretch plus one cycles after the master lets it go
  assign o_scl_oe = hold == 8'h00 && !(i_mst_scl_oe && !mst_q && i_stretch != 8'h00);
  assign o_sda_oe = i_send ? bit_q : !ack_on;
endmodule : twp_slave_model
`default_nettype wire

/* File: verif/twp_master_test.sv */
// Purpose: Self-checking bench of the two-wire master.
// Assumes: Slave model on pulled-up lines; rate set to 3.
// Notes: The monitor shifts SDA in at each SCL rise.
`timescale 1ns/1ps
`default_nettype none
module twp_master_test;
  logic i_ref_clk, i_reset, psel, penable, pwrite, pready, pslverr, o_scl, o_scl_oe, o_sda, o_sda_oe, o_irq;
  logic s_scl_oe, s_sda_oe, s_clr, s_ack, s_send, err_q;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic [7:0] paddr, s_byte, s_stretch;
  logic [8:0] cap = 9'h000;
  logic [31:0] pwdata, prdata, q;
  int num_errors = 0;
  int compares = 0;
  int rises = 0;
  int stops = 0;
  wire logic scl_w = o_scl_oe & s_scl_oe;
  wire logic sda_w = o_sda_oe & s_sda_oe;
  twp_master twp_master_inst (.i_ref_clk, .i_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .i_scl(scl_w), .o_scl, .o_scl_oe, .i_sda(sda_w), .o_sda, .o_sda_oe, .o_irq);
  twp_slave_model twp_slave_model_inst (.i_ref_clk, .i_clr(s_clr), .i_scl(scl_w), .i_mst_scl_oe(o_scl_oe),
    .i_ack(s_ack), .i_send(s_send), .i_byte(s_byte), .i_stretch(s_stretch), .o_scl_oe(s_scl_oe),
    .o_sda_oe(s_sda_oe));
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    scl_q <= scl_w;
    sda_q <= sda_w;
    if (!scl_q && scl_w) begin
      cap <= {cap[7:0], sda_w};
      rises <= rises + 1;
    end
    if (scl_w && !sda_q && sda_w) stops <= stops + 1;
  end
  task automatic wrap_up();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_ref_clk);
  endtask : apb
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rc
  task automatic wait_irq();
    int n;
    n = 0;
    while (o_irq !== 1'b1 && n < 2000) begin
      @(posedge i_ref_clk);
      n++;
    end
    if (n >= 2000) begin
      num_errors++;
      wrap_up();
    end
  endtask : wait_irq
  task automatic rx_run(input logic [7:0] b);
    s_send <= 1'b1;
    s_byte <= b;
    s_clr <= 1'b1;
    @(posedge i_ref_clk);
    s_clr <= 1'b0;
    apb(1'b1, twp_pkg::ADDR_CTRL2, 32'h8);
  endtask : rx_run
  task automatic t_reset();
    rc(twp_pkg::ADDR_RATE, 32'h5);
    rc(twp_pkg::ADDR_STAT, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({q[30:0], err_q}, 32'h1);
    apb(1'b1, twp_pkg::ADDR_CTRL, 32'h7);
    apb(1'b1, twp_pkg::ADDR_RATE, 32'h83);
    rc(twp_pkg::ADDR_RATE, 32'h3);
    $display("test reset done");
  endtask : t_reset
  task automatic t_tx(input logic [7:0] b, input logic ack);
    s_send <= 1'b0;
    s_ack <= ack;
    s_clr <= 1'b1;
    @(posedge i_ref_clk);
    s_clr <= 1'b0;
    apb(1'b1, twp_pkg::ADDR_DATA, {24'h0, b});
    rc(twp_pkg::ADDR_STAT, 32'h41);
    apb(1'b1, twp_pkg::ADDR_DATA, 32'hff);
    wait_irq();
    chk({23'h0, cap}, {23'h0, b, !ack});
    rc(twp_pkg::ADDR_STAT, {26'h0, 2'b10, !ack, 3'b010});
    chk({30'h0, scl_w, sda_w}, 32'h1);
    apb(1'b1, twp_pkg::ADDR_STAT, 32'h0);
    @(posedge i_ref_clk);
    chk({31'h0, o_irq}, 32'h0);
    $display("test tx done");
  endtask : t_tx
  task automatic t_ovf();
    s_stretch <= 8'h14;
    rx_run(8'h96);
    wait_irq();
    apb(1'b1, twp_pkg::ADDR_STAT, 32'h0);
    rx_run(8'h69);
    wait_irq();
    rc(twp_pkg::ADDR_STAT, 32'h2d);
    apb(1'b1, twp_pkg::ADDR_CTRL, 32'h3);
    @(posedge i_ref_clk);
    chk({31'h0, o_irq}, 32'h0);
    apb(1'b1, twp_pkg::ADDR_CTRL, 32'h7);
    apb(1'b0, twp_pkg::ADDR_DATA, 32'h0);
    apb(1'b1, twp_pkg::ADDR_STAT, 32'h0);
    $display("test overflow done");
  endtask : t_ovf
  task automatic t_rx(input logic [7:0] b);
    rx_run(b);
    apb(1'b1, twp_pkg::ADDR_DATA, 32'h55);
    apb(1'b1, twp_pkg::ADDR_CTRL2, 32'h2);
    wait_irq();
    rc(twp_pkg::ADDR_CTRL2, 32'h0);
    rc(twp_pkg::ADDR_STAT, 32'h2b);
    rc(twp_pkg::ADDR_DATA, {24'h0, b});
    rc(twp_pkg::ADDR_STAT, 32'h2a);
    apb(1'b1, twp_pkg::ADDR_STAT, 32'h0);
    $display("test rx done");
  endtask : t_rx
  task automatic t_ack();
    int n;
    n = rises;
    apb(1'b1, twp_pkg::ADDR_CTRL2, 32'h10);
    apb(1'b1, twp_pkg::ADDR_CTRL2, 32'h8);
    rc(twp_pkg::ADDR_STAT, 32'h48);
    wait_irq();
    chk(32'(rises - n), 32'h1);
    chk({30'h0, cap[0], scl_w}, 32'h0);
    rc(twp_pkg::ADDR_CTRL2, 32'h0);
    rc(twp_pkg::ADDR_STAT, 32'h28);
    apb(1'b1, twp_pkg::ADDR_STAT, 32'h0);
    $display("test ack done");
  endtask : t_ack
  task automatic t_stop(input logic [7:0] b);
    int n;
    n = stops;
    apb(1'b1, twp_pkg::ADDR_CTRL2, 32'h2);
    apb(1'b1, twp_pkg::ADDR_DATA, 32'h55);
    wait_irq();
    chk({30'h0, stops != n, cap[0]}, 32'h2);
    rc(twp_pkg::ADDR_CTRL2, 32'h0);
    rc(twp_pkg::ADDR_STAT, 32'h3a);
    rc(twp_pkg::ADDR_DATA, {24'h0, b});
    apb(1'b1, twp_pkg::ADDR_STAT, 32'h0);
    $display("test stop done");
  endtask : t_stop
  task automatic t_mode();
    int n;
    apb(1'b1, twp_pkg::ADDR_CTRL, 32'h1);
    n = rises;
    apb(1'b1, twp_pkg::ADDR_DATA, 32'h3c);
    repeat (40) @(posedge i_ref_clk);
    chk(32'(rises - n), 32'h0);
    $display("test mode done");
  endtask : t_mode
  initial begin
    {i_reset, psel, penable, pwrite, s_clr, s_ack, s_send} = 7'h40;
    {paddr, pwdata, s_byte, s_stretch} = '0;
    repeat (8) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    @(posedge i_ref_clk);
    t_reset();
    t_tx(8'ha5, 1'b1);
    t_tx(8'h5a, 1'b0);
    t_ovf();
    t_rx(8'hc3);
    t_ack();
    t_stop(8'hc3);
    t_mode();
    wrap_up();
  end
endmodule : twp_master_test
`default_nettype wire
